// ### hw/rsc_decode.sv
// remap limit and system-management RAM control with request decode
// Functional notes
// - limit field is address bits 35..26
// - low limit bits taken as ones
// - limit below base disables window
// - limit write-locked by trusted locks; resets zero
// - open/close/lock need global enable
// - open, unlocked: visible without management mode
// - close refuses data, allows code fetch
// - lock clears open, freezes protected fields
// - lock set by write, cleared by reset
// - global enable gives 128 KB at A0000h
// - extended region needs global enable
// - locked global enable holds until reset
// - base segment reads fixed 010b
// - failing compat access goes to link
// - base field is inclusive lower bound
`timescale 1ns/1ns
`include "rsc_map.svh"
module rsc_decode
    import rsc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [1:0]  cfg_be,
    input  wire logic [15:0] cfg_wdata,
    output logic      [15:0] cfg_rdata,
    input  wire logic        trusted_lock,
    input  wire logic        stolen_lock,
    input  wire logic        host_request_strobe,
    input  wire logic [35:0] req_addr,
    input  wire logic        req_sysmgmt,
    input  wire logic        req_code,
    output logic             req_valid,
    output rsc_dest_t        req_dest,
    output logic             req_remap_hit,
    output logic             ext_region_enable,
    output logic             region_lock_state
);
    // ------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------
    logic        tlock;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_bottom;
    logic        wr_top;
    logic        wr_ctl;
    always_comb begin
        // either lock input drops both window field writes
        tlock     = trusted_lock | stolen_lock;
        wr_lo     = cfg_wr && cfg_be[0];
        wr_hi     = cfg_wr && cfg_be[1];
        wr_bottom = 1'b0;
        wr_top    = 1'b0;
        if (cfg_addr == `RSC_OFS_BOTTOM) begin
            wr_bottom = !tlock;
        end else if (cfg_addr == `RSC_OFS_TOP) begin
            wr_top = !tlock;
        end
        wr_ctl    = cfg_wr && (cfg_addr == `RSC_OFS_CONTROL) && cfg_be[0];
    end
    // ------------------------------------------------------------
    // remap window fields
    // ------------------------------------------------------------
    logic [9:0]  bottom_q;
    logic [9:0]  bottom_d;
    logic [9:0]  top_q;
    logic [9:0]  top_d;
    always_comb begin
        bottom_d = bottom_q;
        top_d    = top_q;
        if (wr_bottom && wr_lo) begin
            bottom_d[7:0] = cfg_wdata[7:0];
        end
        if (wr_bottom && wr_hi) begin
            bottom_d[9:8] = cfg_wdata[9:8];
        end
        if (wr_top && wr_lo) begin
            top_d[7:0] = cfg_wdata[7:0];
        end
        if (wr_top && wr_hi) begin
            top_d[9:8] = cfg_wdata[9:8];
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bottom_q <= `RSC_BOTTOM_RESET;
            top_q    <= `RSC_TOP_RESET;
        end else begin
            bottom_q <= bottom_d;
            top_q    <= top_d;
        end
    end
    // ------------------------------------------------------------
    // system-management RAM control
    // ------------------------------------------------------------
    logic        open_q;
    logic        open_d;
    logic        closed_q;
    logic        closed_d;
    logic        locked_q;
    logic        locked_d;
    logic        global_q;
    logic        global_d;
    logic        frozen;
    always_comb begin
        // a stored lock only bites once global enable is set
        frozen   = locked_q && global_q;
        open_d   = open_q;
        closed_d = closed_q;
        locked_d = locked_q;
        global_d = global_q;
        if (wr_ctl) begin
            closed_d = cfg_wdata[`RSC_BIT_CLOSED];
            if (!frozen) begin
                open_d   = cfg_wdata[`RSC_BIT_OPEN];
                global_d = cfg_wdata[`RSC_BIT_GLOBAL];
            end
            // sticky: software may set the lock, never clear it
            if (!locked_q) begin
                locked_d = cfg_wdata[`RSC_BIT_LOCKED];
            end
        end
        if (locked_d && global_d) begin
            open_d = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            open_q   <= 1'b0;
            closed_q <= 1'b0;
            locked_q <= 1'b0;
            global_q <= 1'b0;
        end else begin
            open_q   <= open_d;
            closed_q <= closed_d;
            locked_q <= locked_d;
            global_q <= global_d;
        end
    end
    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [15:0] rdata_d;
    always_comb begin
        rdata_d = 16'h0000;
        if (cfg_rd) begin
            if (cfg_addr == `RSC_OFS_BOTTOM) begin
                rdata_d = {6'h00, bottom_q};
            end else if (cfg_addr == `RSC_OFS_TOP) begin
                rdata_d = {6'h00, top_q};
            end else if (cfg_addr == `RSC_OFS_CONTROL) begin
                rdata_d = {8'h00, 1'b0, open_q, closed_q, locked_q, global_q,
                           `RSC_SEG_FIXED};
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cfg_rdata <= 16'h0000;
        end else begin
            cfg_rdata <= rdata_d;
        end
    end
    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic      win_hit;
    logic      compat;
    logic      visible;
    logic      valid_d;
    logic      remap_d;
    logic      ext_d;
    logic      lock_d;
    rsc_dest_t dest_d;
    rsc_window u_window (
        .bottom (bottom_q),
        .top    (top_q),
        .addr   (req_addr),
        .hit    (win_hit)
    );
    always_comb begin
        compat  = (req_addr >= `RSC_COMPAT_LO) && (req_addr <= `RSC_COMPAT_HI);
        // gated by global enable; close only blocks data references
        visible = global_q && (
                      (open_q && !locked_q) ||
                      (req_sysmgmt && (!closed_q || req_code)));
        valid_d = host_request_strobe;
        dest_d  = RSC_DEST_NONE;
        remap_d = 1'b0;
        if (host_request_strobe) begin
            if (compat) begin
                dest_d = visible ? RSC_DEST_DRAM : RSC_DEST_LINK;
            end else begin
                // other decodes are outside this block
                dest_d  = RSC_DEST_DRAM;
                remap_d = win_hit;
            end
        end
        ext_d  = global_q;
        lock_d = locked_q && global_q;
    end
    // ------------------------------------------------------------
    // decode output registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            req_valid         <= 1'b0;
            req_dest          <= RSC_DEST_NONE;
            req_remap_hit     <= 1'b0;
            ext_region_enable <= 1'b0;
            region_lock_state <= 1'b0;
        end else begin
            req_valid         <= valid_d;
            req_dest          <= dest_d;
            req_remap_hit     <= remap_d;
            ext_region_enable <= ext_d;
            region_lock_state <= lock_d;
        end
    end
endmodule // rsc_decode

// ### shared/rsc_map.svh
// register offsets, field positions and reset values of the decode block
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
`define RSC_OFS_BOTTOM      8'h98
`define RSC_OFS_TOP         8'h9a
`define RSC_OFS_CONTROL     8'h9d
`define RSC_BOTTOM_RESET    10'h3ff
`define RSC_TOP_RESET       10'h000
`define RSC_SEG_FIXED       3'h2
`define RSC_BIT_OPEN        6
`define RSC_BIT_CLOSED      5
`define RSC_BIT_LOCKED      4
`define RSC_BIT_GLOBAL      3
`define RSC_COMPAT_LO       36'h0000a0000
`define RSC_COMPAT_HI       36'h0000bffff
`define RSC_LOW_ONES        26'h3ffffff
`define RSC_LOW_ZERO        26'h0000000
`endif

// ### shared/rsc_pkg.sv
// types of the remap and system-management RAM decode block
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_DEST_NONE = 2'h0,
        RSC_DEST_DRAM = 2'h1,
        RSC_DEST_LINK = 2'h3
    } rsc_dest_t;
endpackage

// ### hw/rsc_window.sv
// inclusive 64 MB granular remap window compare
`timescale 1ns/1ns
`include "rsc_map.svh"
module rsc_window
    import rsc_pkg::*;
(
    input  wire logic [9:0]  bottom,
    input  wire logic [9:0]  top,
    input  wire logic [35:0] addr,
    output logic             hit
);
    logic [35:0] lo;
    logic [35:0] hi;
    always_comb begin
        lo  = {bottom, `RSC_LOW_ZERO};
        hi  = {top, `RSC_LOW_ONES};
        hit = (top >= bottom) && (addr >= lo) && (addr <= hi);
    end
endmodule // rsc_window

// ### testbench/rsc_decode_monitor.sv
// checker of decode block port relations
`timescale 1ns/1ns
module rsc_decode_monitor
    import rsc_pkg::*;
(
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        cfg_rd,
    input wire logic [7:0]  cfg_addr,
    input wire logic [15:0] cfg_rdata,
    input wire logic        host_request_strobe,
    input wire logic [35:0] req_addr,
    input wire logic        req_valid,
    input wire rsc_dest_t   req_dest,
    input wire logic        req_remap_hit,
    input wire logic        ext_region_enable,
    input wire logic        region_lock_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic cpt;
    assign cpt = req_addr >= 36'h0000a0000 && req_addr <= 36'h0000bffff;
    a_valid_follows: assert property (host_request_strobe |=> req_valid)
        else $error("no valid");
    a_idle_none: assert property (!host_request_strobe |=> req_dest == RSC_DEST_NONE)
        else $error("idle route");
    a_seg_fixed: assert property (cfg_rd && cfg_addr == 8'h9d |=> cfg_rdata ==
        {9'h000, cfg_rdata[6:3], 3'h2}) else $error("segment");
    a_open_forced: assert property (cfg_rd && cfg_addr == 8'h9d && region_lock_state
        |=> !cfg_rdata[6]) else $error("open kept");
    a_lock_sticky: assert property (region_lock_state |=> region_lock_state)
        else $error("lock lost");
    a_lock_gated: assert property (region_lock_state |-> ext_region_enable)
        else $error("lock ungated");
    a_compat_link: assert property (host_request_strobe && cpt
        |=> ext_region_enable || req_dest == RSC_DEST_LINK) else $error("compat route");
    a_plain_dram: assert property (host_request_strobe && !cpt
        |=> req_dest == RSC_DEST_DRAM) else $error("plain route");
    a_rdata_idle: assert property (!cfg_rd |=> cfg_rdata == 16'h0000)
        else $error("rdata not idle");
    a_compat_plain: assert property (host_request_strobe && cpt |=> !req_remap_hit)
        else $error("compat remap");
endmodule // rsc_decode_monitor
bind rsc_decode rsc_decode_monitor u_mon (.clock, .rstn, .cfg_rd, .cfg_addr, .cfg_rdata,
    .host_request_strobe, .req_addr, .req_valid, .req_dest, .req_remap_hit,
    .ext_region_enable, .region_lock_state);

// ### testbench/rsc_host.sv
// host side request issuer
`timescale 1ns/1ns
module rsc_host (
    input  wire logic clock,
    output logic      strobe,
    output logic [35:0] addr,
    output logic      sm,
    output logic      code
);
    initial {strobe, addr, sm, code} = '0;
    task automatic issue(input logic [35:0] a, input logic s, input logic c);
        {strobe, addr, sm, code} = {1'b1, a, s, c};
        @(posedge clock) #1;
        {strobe, addr, sm, code} = {1'b0, ~a, ~s, ~c};
    endtask
endmodule // rsc_host

// ### testbench/test_remap_limit_and_sysmgmt_ram_control_control.sv
// self-checking bench of the decode block
`timescale 1ns/1ns
`include "rsc_map.svh"
module test_remap_limit_and_sysmgmt_ram_control_control;
    logic clock = 0, rstn = 0, wr = 0, rd = 0, tl = 0, sl = 0;
    logic [7:0] ad = 0, c;
    logic [1:0] be = 0;
    logic [15:0] wd = 0, rdat;
    logic [35:0] ra, a;
    logic stb, sm, code, vld, hit, ext, lks;
    logic [1:0] dst;
    logic [9:0] top, bot;
    logic opn, cls, lck, glb;
    int fails = 0, compares = 0;
    always #50 clock = ~clock;
    rsc_decode u_dut (.clock, .rstn, .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(ad), .cfg_be(be),
        .cfg_wdata(wd), .cfg_rdata(rdat), .trusted_lock(tl), .stolen_lock(sl),
        .host_request_strobe(stb), .req_addr(ra), .req_sysmgmt(sm), .req_code(code),
        .req_valid(vld), .req_dest(dst), .req_remap_hit(hit), .ext_region_enable(ext),
        .region_lock_state(lks));
    rsc_host u_host (.clock, .strobe(stb), .addr(ra), .sm, .code);
    task automatic print_verdict;
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick;
        @(posedge clock) #1;
    endtask
    task automatic reset_all(input int n);
        rstn = 0;
        repeat (n) tick;
        rstn = 1;
        {top, bot, opn, cls, lck, glb} = {10'h000, 10'h3ff, 4'h0};
    endtask
    task automatic wr_reg(input logic [7:0] r, input logic [1:0] b, input logic [15:0] d);
        logic [9:0] v;
        {wr, ad, be, wd} = {1'b1, r, b, d};
        tick;
        wr = 0;
        tick;
        v = (r == 8'h9a) ? top : bot;
        if (b[0]) v[7:0] = d[7:0];
        if (b[1]) v[9:8] = d[9:8];
        if (!(tl | sl) && r == 8'h9a) top = v;
        if (!(tl | sl) && r == 8'h98) bot = v;
        if (r == 8'h9d && b[0]) cls = d[5];
        if (r == 8'h9d && b[0] && !(lck && glb)) {opn, glb} = {d[6], d[3]};
        if (r == 8'h9d && b[0] && !lck) lck = d[4];
        if (lck && glb) opn = 0;
    endtask
    task automatic rd_reg(input logic [7:0] r, input logic [15:0] e);
        {rd, ad} = {1'b1, r};
        tick;
        rd = 0;
        chk("rdata", e, rdat);
    endtask
    task automatic rd_all;
        rd_reg(8'h9a, {6'h00, top});
        rd_reg(8'h98, {6'h00, bot});
        rd_reg(8'h9d, {9'h000, opn, cls, lck, glb, 3'h2});
        rd_reg(8'h9c, 16'h0000);
    endtask
    task automatic req(input logic s, input logic k);
        logic cp, vis;
        cp = a >= `RSC_COMPAT_LO && a <= `RSC_COMPAT_HI;
        vis = glb && ((s && !(cls && !k)) || (opn && !lck));
        u_host.issue(a, s, k);
        chk("valid", 1, vld);
        chk("dest", (cp && !vis) ? 3 : 1, dst);
        chk("hit", !cp && bot <= top && a[35:26] >= bot && a[35:26] <= top, hit);
        chk("ext", glb, ext);
        chk("lock", lck & glb, lks);
    endtask
    initial begin
        #5000000;
        fails++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h7819));
        reset_all(12);
        rd_all;
        for (int i = 0; i < 170; i++) begin
            {tl, sl} = ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
            wr_reg(8'h9a, 2'($urandom % 3 + 1), 16'($urandom));
            wr_reg(8'h98, 2'($urandom % 3 + 1), 16'($urandom));
            c = 8'($urandom) & 8'hef;
            if (i == 149) c = 8'h00;
            if (i == 150) c = 8'h10;
            if (i == 151) c = 8'h18;
            if (i > 151) c = 8'($urandom) & 8'he7;
            if (c[6]) c[5] = 0;
            wr_reg(8'h9d, 2'h1, {8'h00, c});
            rd_all;
            case ($urandom % 6)
                0: a = `RSC_COMPAT_LO + 36'($urandom % 32'h20000);
                1: a = {top, `RSC_LOW_ONES};
                2: a = {top + 10'h1, `RSC_LOW_ZERO};
                3: a = {bot - 10'h1, `RSC_LOW_ONES};
                4: a = {bot, `RSC_LOW_ZERO};
                default: a = {4'($urandom), $urandom};
            endcase
            req(1'($urandom), 1'($urandom));
        end
        reset_all(1);
        rd_all;
        print_verdict;
    end
endmodule // test_remap_limit_and_sysmgmt_ram_control_control
